// ===== core/blr_regs.sv
// register bank and control logic of the buck4 channel and ldo1 active set.
// assumes analog pins are asynchronous and the step sequencer shares the
// system clock.
//
// Operation
// - per-state bit 7 enables the regulator in that power state.
// - per-state bit 6 selects forced pwm, else automatic pulse skipping.
// - low six bits give the output voltage code per power state.
// - buck voltage codes reset to the 1.8 V code in every state.
// - ldo1 active voltage code takes its default from the six code pins.
// - sequencing bits 7-6 choose the soft start ramp rate.
// - sequencing bits 5-4 assign the channel a power-up step.
// - without participation, no start at step and flags ignored.
// - three-bit delay from step start to soft start begin.
// - fault mask set keeps a fault off the interrupt pin.
// - hiccup set retries soft start on each short, others stay up.
// - hiccup clear shuts all channels, restarts after 100 ms.
// - configuration bit 5 enables active discharge when turned off.
// - phase bit one switches 180 degrees out of phase.
// - configuration bits 3-2 set the voltage scaling rate.
// - override bit lets the register enable bit switch the channel.
// - under override the mode still follows the per-state bit.
module blr_regs
    import blr_pkg::*;
#(
    parameter int unsigned RESTART_CYCLES = BLR_RESTART_CYC,
    parameter int unsigned DLY_UNIT_CYC   = BLR_DLY_UNIT_CYC
)(
    input  wire logic       i_sys_clk,
    input  wire logic       i_sys_rst,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    input  wire logic [1:0] i_power_state,
    input  wire logic [5:0] i_ldo1_code_pins,
    input  wire logic       i_buck4_short,
    input  wire logic       i_buck4_ss_done,
    input  wire logic       i_buck4_power_good,
    input  wire logic       i_seq_step_go,
    input  wire logic [1:0] i_seq_step,
    output logic            o_buck4_enable,
    output logic            o_buck4_forced_pwm,
    output logic      [5:0] o_buck4_output_voltage_code,
    output logic      [1:0] o_buck4_soft_start_rate,
    output logic            o_buck4_ss_start,
    output logic            o_buck4_step_ready,
    output logic            o_buck4_output_discharge_enable,
    output logic            o_buck4_phase_shift,
    output logic      [1:0] o_buck4_scaling_rate,
    output logic            o_all_shutdown,
    output logic            o_seq_restart,
    output logic            o_ldo1_enable,
    output logic      [5:0] o_ldo1_output_voltage_code,
    output logic            o_interrupt_out_n,
    output logic            o_irq
);
    localparam int RW = $clog2(RESTART_CYCLES + 1);
    localparam int DW = $clog2(7 * DLY_UNIT_CYC + 2);

    typedef struct packed {
        logic [1:0]    ps_s1;
        logic [1:0]    ps_s2;
        logic [1:0]    ps_prev;
        logic          flt_s1;
        logic          flt_s2;
        logic          flt_prev;
        logic          ssd_s1;
        logic          ssd_s2;
        logic          pok_s1;
        logic          pok_s2;
        logic [5:0]    pin_s1;
        logic [5:0]    pin_s2;
        logic [1:0]    strap_wait;
        logic          strap_done;
        logic [7:0]    set_act;
        logic [7:0]    set_lpm;
        logic [7:0]    set_hib;
        logic [7:0]    set_hpm;
        logic [7:0]    seq;
        logic [7:0]    cfg;
        logic [7:0]    ldo_act;
        logic [3:0]    stat;
        logic [3:0]    mask;
        logic [7:0]    rdata;
        logic          seq_wait;
        logic [DW-1:0] dly_cnt;
        logic          seq_on;
        logic          shut;
        logic [RW-1:0] rst_cnt;
        logic          ss_start;
        logic          restart;
        logic          en;
        logic          pwm;
        logic [5:0]    code;
        logic          step_ready;
        logic          intn;
        logic          irq;
    } blr_state_t;

    blr_state_t r_reg;
    blr_state_t r_next;
    logic [3:0] ev;
    logic [3:0] clr;
    logic       flt_rise;

    blr_sel_if sel_bus ();

    assign sel_bus.pstate  = blr_pstate_t'(r_reg.ps_s2);
    assign sel_bus.set_act = r_reg.set_act;
    assign sel_bus.set_lpm = r_reg.set_lpm;
    assign sel_bus.set_hib = r_reg.set_hib;
    assign sel_bus.set_hpm = r_reg.set_hpm;

    blr_state_sel u_sel (
        .s (sel_bus.sel)
    );

    function automatic logic [DW-1:0] dly_cycles(input logic [2:0] d);
        return DW'(d) * DW'(DLY_UNIT_CYC);
    endfunction

    always_comb begin
        r_next = r_reg;
        ev     = 4'h0;
        clr    = 4'h0;

        // two-stage synchronisers for every asynchronous pin
        r_next.ps_s1   = i_power_state;
        r_next.ps_s2   = r_reg.ps_s1;
        r_next.ps_prev = r_reg.ps_s2;
        r_next.flt_s1  = i_buck4_short;
        r_next.flt_s2  = r_reg.flt_s1;
        r_next.flt_prev = r_reg.flt_s2;
        r_next.ssd_s1  = i_buck4_ss_done;
        r_next.ssd_s2  = r_reg.ssd_s1;
        r_next.pok_s1  = i_buck4_power_good;
        r_next.pok_s2  = r_reg.pok_s1;
        r_next.pin_s1  = i_ldo1_code_pins;
        r_next.pin_s2  = r_reg.pin_s1;
        flt_rise       = r_reg.flt_s2 & ~r_reg.flt_prev;

        r_next.ss_start = 1'b0;
        r_next.restart  = 1'b0;
        r_next.rdata    = 8'h00;

        // the strap is taken once the synchroniser holds post-reset data
        if (r_reg.strap_wait != 2'h3) begin
            r_next.strap_wait = r_reg.strap_wait + 2'h1;
        end else if (!r_reg.strap_done) begin
            r_next.strap_done = 1'b1;
            r_next.ldo_act    = {BLR_RST_L1_EN, 1'b0, r_reg.pin_s2};
        end

        if (i_wr) begin
            case (i_addr)
                BLR_OFS_B4_ACT: r_next.set_act = i_wdata;
                BLR_OFS_B4_LPM: r_next.set_lpm = i_wdata;
                BLR_OFS_B4_HIB: r_next.set_hib = i_wdata;
                BLR_OFS_B4_HPM: r_next.set_hpm = i_wdata;
                BLR_OFS_B4_SEQ: r_next.seq     = i_wdata;
                BLR_OFS_B4_CFG: r_next.cfg     = i_wdata;
                // reserved bit is not stored, so a stray one cannot stick
                BLR_OFS_L1_ACT: r_next.ldo_act = i_wdata & BLR_L1_WMASK;
                BLR_OFS_MASK:   r_next.mask    = i_wdata[3:0];
                default:        r_next.mask    = r_reg.mask;
            endcase
        end

        if (i_rd) begin
            case (i_addr)
                BLR_OFS_B4_ACT: r_next.rdata = r_reg.set_act;
                BLR_OFS_B4_LPM: r_next.rdata = r_reg.set_lpm;
                BLR_OFS_B4_HIB: r_next.rdata = r_reg.set_hib;
                BLR_OFS_B4_HPM: r_next.rdata = r_reg.set_hpm;
                BLR_OFS_B4_SEQ: r_next.rdata = r_reg.seq;
                BLR_OFS_B4_CFG: r_next.rdata = r_reg.cfg;
                BLR_OFS_L1_ACT: r_next.rdata = r_reg.ldo_act;
                BLR_OFS_MASK:   r_next.rdata = {4'h0, r_reg.mask};
                BLR_OFS_STATUS: begin
                    r_next.rdata = {4'h0, r_reg.stat};
                    clr          = r_reg.stat;
                end
                default:        r_next.rdata = 8'h00;
            endcase
        end

        // step start: only a participating channel arms its delay
        if (i_seq_step_go && r_reg.seq[BLR_SEQ_PART] && !r_reg.shut &&
            r_reg.seq[BLR_SEQ_STEP_HI:BLR_SEQ_STEP_LO] == i_seq_step) begin
            r_next.seq_wait = 1'b1;
            r_next.dly_cnt  = dly_cycles(
                r_reg.seq[BLR_SEQ_DLY_HI:BLR_SEQ_DLY_LO]);
        end else if (r_reg.seq_wait) begin
            if (r_reg.dly_cnt == '0) begin
                r_next.seq_wait = 1'b0;
                r_next.seq_on   = 1'b1;
                r_next.ss_start = 1'b1;
            end else begin
                r_next.dly_cnt = r_reg.dly_cnt - DW'(1);
            end
        end

        // short circuit response
        if (flt_rise && !r_reg.shut) begin
            ev[BLR_ST_FAULT] = 1'b1;
            if (r_reg.cfg[BLR_CFG_HICCUP]) begin
                // only this channel retries; no limit on attempts
                r_next.ss_start = r_reg.en;
            end else begin
                r_next.shut     = 1'b1;
                r_next.rst_cnt  = RW'(RESTART_CYCLES - 1);
                r_next.seq_on   = 1'b0;
                r_next.seq_wait = 1'b0;
                ev[BLR_ST_SHUT] = 1'b1;
            end
        end else if (r_reg.shut) begin
            if (r_reg.rst_cnt == '0) begin
                r_next.shut        = 1'b0;
                r_next.restart     = 1'b1;
                ev[BLR_ST_RESTART] = 1'b1;
            end else begin
                r_next.rst_cnt = r_reg.rst_cnt - RW'(1);
            end
        end

        ev[BLR_ST_PSTATE] = r_reg.ps_s2 != r_reg.ps_prev;

        // a new event in the clearing read cycle survives
        r_next.stat = (r_reg.stat & ~clr) | ev;

        // override takes the switch, mode stays with the power state
        if (r_next.shut) begin
            r_next.en = 1'b0;
        end else if (r_reg.cfg[BLR_CFG_REG_OVERRIDE]) begin
            r_next.en = r_reg.cfg[BLR_CFG_REN];
        end else begin
            r_next.en = sel_bus.sel_en & r_next.seq_on;
        end
        r_next.pwm  = sel_bus.sel_pwm;
        r_next.code = sel_bus.sel_code;

        // a non-participating channel never holds the sequencer back
        r_next.step_ready = !r_reg.seq[BLR_SEQ_PART] |
                            (r_reg.seq_on & r_reg.ssd_s2 & r_reg.pok_s2);

        r_next.intn = !(r_next.stat[BLR_ST_FAULT] &
                        !r_reg.cfg[BLR_CFG_FMASK]);
        r_next.irq  = |(r_next.stat & r_reg.mask);
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            r_reg         <= '0;
            r_reg.set_act <= BLR_RST_B4_ACT;
            r_reg.set_lpm <= BLR_RST_B4_LPM;
            r_reg.set_hib <= BLR_RST_B4_HIB;
            r_reg.set_hpm <= BLR_RST_B4_HPM;
            r_reg.seq     <= BLR_RST_B4_SEQ;
            r_reg.cfg     <= BLR_RST_B4_CFG;
            r_reg.ldo_act <= {BLR_RST_L1_EN, 7'h00};
            r_reg.mask    <= BLR_RST_MASK;
            r_reg.intn    <= 1'b1;
            r_reg.step_ready <= 1'b0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign o_rdata                     = r_reg.rdata;
    assign o_buck4_enable              = r_reg.en;
    assign o_buck4_forced_pwm          = r_reg.pwm;
    assign o_buck4_output_voltage_code = r_reg.code;
    assign o_buck4_soft_start_rate     =
        r_reg.seq[BLR_SEQ_SSR_HI:BLR_SEQ_SSR_LO];
    assign o_buck4_ss_start            = r_reg.ss_start;
    assign o_buck4_step_ready          = r_reg.step_ready;
    // one enables discharge; the opposite reading is not supported
    assign o_buck4_output_discharge_enable =
        r_reg.cfg[BLR_CFG_OUTPUT_DISCHARGE_ENABLE];
    assign o_buck4_phase_shift         = r_reg.cfg[BLR_CFG_PHASE];
    assign o_buck4_scaling_rate        =
        r_reg.cfg[BLR_CFG_RATE_HI:BLR_CFG_RATE_LO];
    assign o_all_shutdown              = r_reg.shut;
    assign o_seq_restart               = r_reg.restart;
    assign o_ldo1_enable               = r_reg.ldo_act[BLR_SET_EN];
    assign o_ldo1_output_voltage_code  =
        r_reg.ldo_act[BLR_SET_CODE_HI:BLR_SET_CODE_LO];
    assign o_interrupt_out_n           = r_reg.intn;
    assign o_irq                       = r_reg.irq;
endmodule

// ===== core/blr_state_sel.sv
// picks the per-state setting register that matches the power state.
// assumes the power state is already synchronised by the register bank.
module blr_state_sel
    import blr_pkg::*;
(
    blr_sel_if.sel s
);
    logic [7:0] pick;

    always_comb begin
        case (s.pstate)
            BLR_PS_ACTIVE:    pick = s.set_act;
            BLR_PS_LOWPOWER:  pick = s.set_lpm;
            BLR_PS_HIBERNATE: pick = s.set_hib;
            BLR_PS_HIGHPERF:  pick = s.set_hpm;
            default:          pick = s.set_act;
        endcase
        s.sel_en   = pick[BLR_SET_EN];
        s.sel_pwm  = pick[BLR_SET_PWM];
        s.sel_code = pick[BLR_SET_CODE_HI:BLR_SET_CODE_LO];
    end
endmodule

// ===== dv/blr_regs_assertions.sv
// checker for the buck4 / ldo1 register bank, bound to blr_regs.
// assumes writes to one register are at least two cycles apart.
module blr_chk
    import blr_pkg::*;
#(
    parameter int unsigned RESTART_CYCLES = 20
)(
    input wire logic       i_sys_clk,
    input wire logic       i_sys_rst,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_wr,
    input wire logic [1:0] i_power_state,
    input wire logic       o_buck4_enable,
    input wire logic       o_buck4_forced_pwm,
    input wire logic [5:0] o_buck4_output_voltage_code,
    input wire logic [1:0] o_buck4_soft_start_rate,
    input wire logic       o_buck4_output_discharge_enable,
    input wire logic       o_buck4_phase_shift,
    input wire logic [1:0] o_buck4_scaling_rate,
    input wire logic       o_all_shutdown,
    input wire logic       o_seq_restart,
    input wire logic       o_interrupt_out_n
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    // counts shutdown cycles so the wait can be bounded both ways
    logic [31:0] shut_cnt_reg;
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst || !o_all_shutdown)
            shut_cnt_reg <= '0;
        else
            shut_cnt_reg <= shut_cnt_reg + 32'h1;
    end
    sequence s_cfg_wr;
        i_wr && i_addr == BLR_OFS_B4_CFG;
    endsequence
    // the active set only shows while the pin says active
    sequence s_act_wr;
        i_wr && i_addr == BLR_OFS_B4_ACT && i_power_state == 2'h0;
    endsequence
    chk_output_discharge_enable_follow: assert property (
        s_cfg_wr |=> ##1
        o_buck4_output_discharge_enable == $past(i_wdata[5], 2))
        else $error("discharge enable mismatch");
    chk_phase_follow: assert property (
        s_cfg_wr |=> ##1 o_buck4_phase_shift == $past(i_wdata[4], 2))
        else $error("phase mismatch");
    chk_rate_follow: assert property (
        s_cfg_wr |=> ##1 o_buck4_scaling_rate == $past(i_wdata[3:2], 2))
        else $error("scaling rate mismatch");
    chk_fault_mask: assert property (
        s_cfg_wr ##0 i_wdata[7] |=> ##1 o_interrupt_out_n)
        else $error("masked fault reached interrupt pin");
    chk_override_en: assert property (
        s_cfg_wr ##0 (i_wdata[0] && !o_all_shutdown) |=> ##1
        o_buck4_enable == $past(i_wdata[1], 2))
        else $error("override enable mismatch");
    chk_ssr_follow: assert property (
        i_wr && i_addr == BLR_OFS_B4_SEQ |=> ##1
        o_buck4_soft_start_rate == $past(i_wdata[7:6], 2))
        else $error("soft start rate mismatch");
    chk_mode_follow: assert property (
        s_act_wr |=> ##1 o_buck4_forced_pwm == $past(i_wdata[6], 2))
        else $error("mode mismatch");
    chk_code_follow: assert property (
        s_act_wr |=> ##1
        o_buck4_output_voltage_code == $past(i_wdata[5:0], 2))
        else $error("voltage code mismatch");
    chk_shut_off: assert property (
        o_all_shutdown && $past(o_all_shutdown) |-> !o_buck4_enable)
        else $error("channel on during shutdown");
    chk_restart_end: assert property (
        $fell(o_all_shutdown) |-> o_seq_restart)
        else $error("no restart at end of shutdown");
    chk_shut_len: assert property (
        $fell(o_all_shutdown) |-> shut_cnt_reg + 1 >= RESTART_CYCLES
        && shut_cnt_reg <= RESTART_CYCLES + 1)
        else $error("shutdown length wrong");
endmodule

bind blr_regs blr_chk #(.RESTART_CYCLES(RESTART_CYCLES)) u_chk (
    .i_sys_clk, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_power_state,
    .o_buck4_enable, .o_buck4_forced_pwm, .o_buck4_output_voltage_code,
    .o_buck4_soft_start_rate, .o_buck4_output_discharge_enable,
    .o_buck4_phase_shift, .o_buck4_scaling_rate, .o_all_shutdown,
    .o_seq_restart, .o_interrupt_out_n
);

// ===== dv/test_buck4_ldo1_channel_regs.sv
// self-checking bench for the buck4 / ldo1 register bank.
// assumes short restart and delay-unit parameters to keep the run brief.
module test_buck4_ldo1_channel_regs
    import blr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RC = 20;
    localparam int DU = 2;
    typedef struct { logic [7:0] a, r, w, e; } blr_row_t;
    logic       i_sys_clk, i_sys_rst, i_wr, i_rd, i_seq_step_go;
    logic [7:0] i_addr, i_wdata, o_rdata, d;
    logic [1:0] i_power_state, i_seq_step;
    logic [5:0] i_ldo1_code_pins;
    logic       i_buck4_short, i_buck4_ss_done, i_buck4_power_good;
    logic       o_buck4_enable, o_buck4_forced_pwm, o_buck4_ss_start;
    logic [5:0] o_buck4_output_voltage_code, o_ldo1_output_voltage_code;
    logic [1:0] o_buck4_soft_start_rate, o_buck4_scaling_rate;
    logic       o_buck4_step_ready, o_buck4_output_discharge_enable;
    logic       o_buck4_phase_shift, o_all_shutdown, o_seq_restart;
    logic       o_ldo1_enable, o_interrupt_out_n, o_irq;
    int         failures = 0;
    int         check_count = 0;
    int         n;
    // reset columns follow the documented power-on pattern
    blr_row_t rows[10] = '{
        '{8'h41, 8'hfd, 8'h2a, 8'h2a}, '{8'h30, 8'hbd, 8'hc5, 8'hc5},
        '{8'h42, 8'hbd, 8'h7f, 8'h7f}, '{8'h43, 8'hfd, 8'h81, 8'h81},
        '{8'h44, 8'h1c, 8'h53, 8'h53}, '{8'h45, 8'ha0, 8'h5c, 8'h5c},
        '{8'h50, 8'hab, 8'h15, 8'h15},
        '{8'h70, 8'h00, 8'hff, 8'h00}, '{8'h71, 8'h00, 8'h0f, 8'h0f},
        '{8'h7f, 8'h00, 8'hff, 8'h00}};

    blr_regs #(.RESTART_CYCLES(RC), .DLY_UNIT_CYC(DU)) u_dut (
        .i_sys_clk, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .i_power_state, .i_ldo1_code_pins, .i_buck4_short,
        .i_buck4_ss_done, .i_buck4_power_good, .i_seq_step_go,
        .i_seq_step, .o_buck4_enable, .o_buck4_forced_pwm,
        .o_buck4_output_voltage_code, .o_buck4_soft_start_rate,
        .o_buck4_ss_start, .o_buck4_step_ready,
        .o_buck4_output_discharge_enable, .o_buck4_phase_shift,
        .o_buck4_scaling_rate, .o_all_shutdown, .o_seq_restart,
        .o_ldo1_enable, .o_ldo1_output_voltage_code, .o_interrupt_out_n,
        .o_irq);

    initial begin
        i_sys_clk = 1'b0;
        forever #4 i_sys_clk = ~i_sys_clk;
    end

    task automatic test_done();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(logic [31:0] got, logic [31:0] exp, string m);
        check_count++;
        if (got !== exp) begin
            $display("BAD %0t %s", $time, m);
            failures++;
        end
    endtask
    task automatic tick(int c);
        repeat (c) @(posedge i_sys_clk);
        #1;
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] v);
        @(posedge i_sys_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, output logic [7:0] v);
        @(posedge i_sys_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1 v = o_rdata;
    endtask
    task automatic go(logic [1:0] s);
        @(posedge i_sys_clk);
        i_seq_step_go <= 1'b1;
        i_seq_step <= s;
        @(posedge i_sys_clk);
        i_seq_step_go <= 1'b0;
    endtask
    // n ends one past the bound when the event never came
    task automatic wt(int w, int b, bit need);
        for (n = 1; n <= b; n++) begin
            tick(1);
            if ((w == 0 && o_buck4_ss_start === 1'b1) ||
                (w == 1 && o_all_shutdown === 1'b1) ||
                (w == 2 && o_seq_restart === 1'b1))
                return;
        end
        if (need) begin
            $display("BAD %0t wait ran out", $time);
            failures++;
            test_done();
        end
    endtask

    initial begin
        {i_sys_rst, i_wr, i_rd, i_seq_step_go, i_buck4_short} = 5'h1f;
        {i_wr, i_rd, i_seq_step_go, i_buck4_short} = 4'h0;
        {i_addr, i_wdata, i_power_state, i_seq_step} = 20'h0;
        {i_buck4_ss_done, i_buck4_power_good} = 2'h3;
        i_ldo1_code_pins = 6'h2b;
        tick(10);
        i_sys_rst <= 1'b0;
        tick(6);
        chk(o_buck4_output_voltage_code, 6'h3d, "reset code");
        chk({o_ldo1_enable, o_ldo1_output_voltage_code}, 7'h6b, "strap");
        foreach (rows[i]) begin
            rd(rows[i].a, d);
            chk(d, rows[i].r, "reset value");
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a, d);
            chk(d, rows[i].e, "readback");
        end
        tick(1);
        chk({o_buck4_soft_start_rate, o_buck4_output_discharge_enable,
             o_buck4_phase_shift, o_buck4_scaling_rate}, 6'h17, "fields");
        chk({o_ldo1_enable, o_ldo1_output_voltage_code}, 7'h15, "ldo");
        $display("test registers done");
        go(2'h1);
        wt(0, 12, 1'b0);
        chk(n, 13, "started without participation");
        chk(o_buck4_step_ready, 1'b1, "ready idle");
        wr(BLR_OFS_B4_SEQ, 8'h5b);
        go(2'h0);
        wt(0, 12, 1'b0);
        chk(n, 13, "started at wrong step");
        go(2'h1);
        wt(0, 12, 1'b1);
        chk(n, 1 + 3 * DU, "start delay");
        tick(4);
        chk({o_buck4_step_ready, o_buck4_enable}, 2'b10, "ready");
        @(posedge i_sys_clk);
        i_buck4_power_good <= 1'b0;
        tick(5);
        chk(o_buck4_step_ready, 1'b0, "ready without power good");
        $display("test sequencing done");
        for (int i = 0; i < 4; i++) begin
            @(posedge i_sys_clk);
            i_power_state <= 2'(i + 2);
            tick(6);
            chk({o_buck4_enable, o_buck4_forced_pwm,
                 o_buck4_output_voltage_code}, rows[(i + 2) % 4].w, "set");
            chk(o_irq, 1'b1, "irq raise");
            rd(BLR_OFS_STATUS, d);
            chk(d, 8'h08, "state event");
            tick(1);
            chk(o_irq, 1'b0, "irq clear");
        end
        $display("test power states done");
        @(posedge i_sys_clk);
        i_buck4_short <= 1'b1;
        wt(0, 8, 1'b1);
        tick(1);
        chk({o_all_shutdown, o_interrupt_out_n}, 2'b00, "hiccup");
        rd(BLR_OFS_STATUS, d);
        chk(d, 8'h01, "short logged");
        i_buck4_short <= 1'b0;
        tick(3);
        chk(o_interrupt_out_n, 1'b1, "fault cleared");
        wr(BLR_OFS_B4_CFG, 8'hdc);
        @(posedge i_sys_clk);
        i_buck4_short <= 1'b1;
        tick(8);
        chk(o_interrupt_out_n, 1'b1, "fault masked");
        @(posedge i_sys_clk);
        i_buck4_short <= 1'b0;
        $display("test hiccup done");
        wr(BLR_OFS_B4_CFG, 8'h21);
        tick(1);
        chk({o_buck4_enable, o_buck4_forced_pwm, o_buck4_output_discharge_enable,
             o_buck4_phase_shift, o_buck4_scaling_rate}, 6'h18, "ovr");
        wr(BLR_OFS_B4_CFG, 8'h22);
        @(posedge i_sys_clk);
        i_power_state <= 2'h0;
        tick(6);
        chk(o_buck4_enable, 1'b0, "enable bit without override");
        wr(BLR_OFS_B4_CFG, 8'h23);
        tick(1);
        chk({o_buck4_enable, o_buck4_forced_pwm}, 2'b10, "override on");
        wr(BLR_OFS_B4_CFG, 8'h20);
        @(posedge i_sys_clk);
        i_power_state <= 2'h1;
        tick(6);
        rd(BLR_OFS_STATUS, d);
        // the masked short earlier left its fault bit set; it is unread
        chk({o_buck4_enable, d}, 9'h109, "override released");
        $display("test override done");
        @(posedge i_sys_clk);
        i_buck4_short <= 1'b1;
        wt(1, 8, 1'b1);
        wt(2, RC + 4, 1'b1);
        chk(n >= RC - 1 && n <= RC + 1, 1'b1, "restart wait");
        chk({o_all_shutdown, o_buck4_enable}, 2'b00, "after restart");
        rd(BLR_OFS_STATUS, d);
        chk(d[2:1], 2'b11, "shutdown logged");
        i_buck4_short <= 1'b0;
        wr(BLR_OFS_MASK, 8'h00);
        i_power_state <= 2'h3;
        tick(6);
        chk(o_irq, 1'b0, "irq masked");
        $display("test shutdown done");
        i_sys_rst <= 1'b1;
        tick(10);
        i_sys_rst <= 1'b0;
        tick(6);
        rd(BLR_OFS_B4_CFG, d);
        chk({o_buck4_output_voltage_code, o_ldo1_enable,
             o_ldo1_output_voltage_code, d}, 21'h1eeba0, "reset");
        $display("test second reset done");
        test_done();
    end
endmodule

// ===== inc/blr_pkg.sv
// constants for the buck4 / ldo1 channel register bank.
// assumes an 8-bit register port and a single 125 MHz system clock.
package blr_pkg;

    // register offsets
    localparam logic [7:0] BLR_OFS_B4_LPM  = 8'h30;
    localparam logic [7:0] BLR_OFS_B4_ACT  = 8'h41;
    localparam logic [7:0] BLR_OFS_B4_HIB  = 8'h42;
    localparam logic [7:0] BLR_OFS_B4_HPM  = 8'h43;
    localparam logic [7:0] BLR_OFS_B4_SEQ  = 8'h44;
    localparam logic [7:0] BLR_OFS_B4_CFG  = 8'h45;
    localparam logic [7:0] BLR_OFS_L1_ACT  = 8'h50;
    localparam logic [7:0] BLR_OFS_STATUS  = 8'h70;
    localparam logic [7:0] BLR_OFS_MASK    = 8'h71;

    // reset values
    localparam logic [7:0] BLR_RST_B4_ACT  = 8'hfd;
    localparam logic [7:0] BLR_RST_B4_LPM  = 8'hbd;
    localparam logic [7:0] BLR_RST_B4_HIB  = 8'hbd;
    localparam logic [7:0] BLR_RST_B4_HPM  = 8'hfd;
    localparam logic [7:0] BLR_RST_B4_SEQ  = 8'h1c;
    localparam logic [7:0] BLR_RST_B4_CFG  = 8'ha0;
    localparam logic       BLR_RST_L1_EN   = 1'b1;
    localparam logic [3:0] BLR_RST_MASK    = 4'h0;

    // per-state setting fields
    localparam int BLR_SET_EN      = 7;
    localparam int BLR_SET_PWM     = 6;
    localparam int BLR_SET_CODE_HI = 5;
    localparam int BLR_SET_CODE_LO = 0;
    localparam logic [7:0] BLR_L1_WMASK = 8'hbf;

    // sequencing fields
    localparam int BLR_SEQ_SSR_HI  = 7;
    localparam int BLR_SEQ_SSR_LO  = 6;
    localparam int BLR_SEQ_STEP_HI = 5;
    localparam int BLR_SEQ_STEP_LO = 4;
    localparam int BLR_SEQ_PART    = 3;
    localparam int BLR_SEQ_DLY_HI  = 2;
    localparam int BLR_SEQ_DLY_LO  = 0;

    // configuration fields
    localparam int BLR_CFG_FMASK   = 7;
    localparam int BLR_CFG_HICCUP  = 6;
    localparam int BLR_CFG_OUTPUT_DISCHARGE_ENABLE   = 5;
    localparam int BLR_CFG_PHASE   = 4;
    localparam int BLR_CFG_RATE_HI = 3;
    localparam int BLR_CFG_RATE_LO = 2;
    localparam int BLR_CFG_REN     = 1;
    localparam int BLR_CFG_REG_OVERRIDE    = 0;

    // status bits
    localparam int BLR_ST_FAULT    = 0;
    localparam int BLR_ST_SHUT     = 1;
    localparam int BLR_ST_RESTART  = 2;
    localparam int BLR_ST_PSTATE   = 3;

    // timing
    localparam int unsigned BLR_CLK_KHZ      = 125000;
    localparam int unsigned BLR_RESTART_MS   = 100;
    localparam int unsigned BLR_RESTART_CYC  = BLR_RESTART_MS * BLR_CLK_KHZ;
    localparam int unsigned BLR_DLY_UNIT_US  = 1;
    localparam int unsigned BLR_DLY_UNIT_CYC =
        BLR_DLY_UNIT_US * BLR_CLK_KHZ / 1000;

    typedef enum logic [1:0] {
        BLR_PS_ACTIVE,
        BLR_PS_LOWPOWER,
        BLR_PS_HIBERNATE,
        BLR_PS_HIGHPERF
    } blr_pstate_t;

endpackage

// ===== inc/blr_sel_if.sv
// carrier between the register bank and its power-state selector.
// assumes both ends sit on the same clock; the path is combinational.
interface blr_sel_if;
    import blr_pkg::*;
    blr_pstate_t pstate;
    logic [7:0]  set_act;
    logic [7:0]  set_lpm;
    logic [7:0]  set_hib;
    logic [7:0]  set_hpm;
    logic        sel_en;
    logic        sel_pwm;
    logic [5:0]  sel_code;
    modport regs (output pstate, set_act, set_lpm, set_hib, set_hpm,
                  input  sel_en, sel_pwm, sel_code);
    modport sel  (input  pstate, set_act, set_lpm, set_hib, set_hpm,
                  output sel_en, sel_pwm, sel_code);
endinterface
